// [hdl/opri_top.v]
// OLED driver power, reset and init state with AXI4-Lite access
// Notes on behaviour
// R01: Host powers up, waits 100ms, then displays
// R02: Host powers down panel, waits 100ms
// R03: Init pin low forces all settings default; the CTRL register bits keep their values
// R04: Reset gives standby, oscillator off, 95Hz
// R05: Column write window resets to 0x00..0x5F
// R06: Row write window resets to 0x00..0x5F
// R07: Direction and increment bits reset zero
// R08: Rows scan ascending through row 95
// R09: Columns shift ascending through column 287
// R10: Visible area resets to 0x00..0x5F
// R11: Read pointers reset to zero
// R12: Discharge resets to 8 clocks
// R13: Peak pulse delay resets to 5
// R14: Peak pulse widths reset to 5
// R15: Precharge and drive currents reset zero
// R16: Host holds init low 100ms, panel off
// R17: Host sends soft reset 0x01/0x00 first
// R18: Host sends memory access 0x1d/0x01
// R19: Host programs window codes 0x30..0x33
// R20: Host turns display on, then panel
// R21: Host resets display after noise corruption
// R22: Panel enable high drives converter on
// R23: Host times waits with a counter
`timescale 1ns/1ns
`default_nettype none
`include "opri_defines.vh"
module opri_top (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire chip_init_n,
  input wire panel_hv_enable,
  output reg panel_hv_on,
  output reg display_on,
  output reg osc_run
);
  // ================================================================
  // Pin synchronisers
  wire init_n_s;
  wire hv_pin_s;
  opri_sync u_sync_init (
    .aclk(aclk),
    .aresetn(aresetn),
    .rst_val(1'b0),
    .d(chip_init_n),
    .q(init_n_s)
  );
  opri_sync u_sync_hv (
    .aclk(aclk),
    .aresetn(aresetn),
    .rst_val(1'b0),
    .d(panel_hv_enable),
    .q(hv_pin_s)
  );

  // ================================================================
  // Settings state
  reg ctrl_init_q, ctrl_hv_q;
  reg standby_q, disp_q, osc_q;
  reg [7:0] frame_q;
  reg [7:0] col_start_q, col_end_q, row_start_q, row_end_q;
  reg mem_dir_hi_q, mem_dir_lo_q, incr_axis_sel_q;
  reg [7:0] view_col_first_q, view_col_last_q;
  reg [7:0] view_row_first_q, view_row_last_q;
  reg [7:0] read_col_ptr_q, read_row_ptr_q;
  reg [7:0] discharge_q, peak_delay_q;
  reg [7:0] peak_w_r_q, peak_w_g_q, peak_w_b_q;
  reg [7:0] pre_r_q, pre_g_q, pre_b_q;
  reg [7:0] drv_r_q, drv_g_q, drv_b_q;
  reg soft_rst_q;

  // Either the pin or software holds the driver in init
  wire init_hold = !init_n_s || !ctrl_init_q || soft_rst_q;

  // ================================================================
  // Scan counters
  wire [7:0] scan_row;
  wire [11:0] scan_col;
  opri_scan u_scan (
    .aclk(aclk),
    .hold(init_hold),
    .run(osc_q && !standby_q),
    .row_q(scan_row),
    .col_q(scan_col)
  );

  // ================================================================
  // AXI4-Lite write path
  reg aw_hold_q, w_hold_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;

  function [7:0] lane_merge;
    input [7:0] old_v;
    input [7:0] new_v;
    input en;
    begin
      lane_merge = en ? new_v : old_v;
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q[7:5] != 3'b000) ? 2'b10 : 2'b00;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  wire wr_ctrl = wr_fire && aw_addr_q == `OPRI_REG_CTRL;
  wire wr_cmd = wr_fire && aw_addr_q == `OPRI_REG_CMD && w_strb_q[0];
  wire [7:0] cmd_code = w_data_q[15:8];
  wire [7:0] cmd_val = w_data_q[7:0];

  // ================================================================
  // Control register, panel enable and command decode
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_init_q <= 1'b1;
      ctrl_hv_q <= 1'b0;
    end else if (wr_ctrl && w_strb_q[0]) begin
      ctrl_init_q <= w_data_q[`OPRI_CTRL_INIT_N];
      ctrl_hv_q <= w_data_q[`OPRI_CTRL_HV];
    end
  end

  always @(posedge aclk) begin
    if (!aresetn)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= wr_cmd && cmd_code == `OPRI_CMD_SOFT_RESET;
  end

  // Code/value pairs land as one word: code in byte 1, value in byte 0
  always @(posedge aclk) begin
    if (!aresetn || init_hold) begin // R03
      standby_q <= 1'b1; // R04
      osc_q <= 1'b0; // R04
      disp_q <= 1'b0; // R04
      frame_q <= `OPRI_RST_FRAME_HZ; // R04
      col_start_q <= `OPRI_RST_COL_START; // R05
      col_end_q <= `OPRI_RST_COL_END; // R05
      row_start_q <= `OPRI_RST_ROW_START; // R06
      row_end_q <= `OPRI_RST_ROW_END; // R06
      mem_dir_hi_q <= 1'b0; // R07
      mem_dir_lo_q <= 1'b0; // R07
      incr_axis_sel_q <= 1'b0; // R07
      view_col_first_q <= `OPRI_RST_COL_START; // R10
      view_col_last_q <= `OPRI_RST_COL_END; // R10
      view_row_first_q <= `OPRI_RST_ROW_START; // R10
      view_row_last_q <= `OPRI_RST_ROW_END; // R10
      read_col_ptr_q <= 8'h00; // R11
      read_row_ptr_q <= 8'h00; // R11
      discharge_q <= `OPRI_RST_DISCHARGE; // R12
      peak_delay_q <= `OPRI_RST_PEAK_DELAY; // R13
      peak_w_r_q <= `OPRI_RST_PEAK_WIDTH; // R14
      peak_w_g_q <= `OPRI_RST_PEAK_WIDTH; // R14
      peak_w_b_q <= `OPRI_RST_PEAK_WIDTH; // R14
      pre_r_q <= `OPRI_RST_CURRENT; // R15
      pre_g_q <= `OPRI_RST_CURRENT; // R15
      pre_b_q <= `OPRI_RST_CURRENT; // R15
      drv_r_q <= `OPRI_RST_CURRENT; // R15
      drv_g_q <= `OPRI_RST_CURRENT; // R15
      drv_b_q <= `OPRI_RST_CURRENT; // R15
    end else if (wr_cmd) begin
      case (cmd_code)
        `OPRI_CMD_DISP_ON_OFF: disp_q <= cmd_val[0];
        `OPRI_CMD_STANDBY: standby_q <= cmd_val[0];
        `OPRI_CMD_OSC: osc_q <= cmd_val[0];
        `OPRI_CMD_MEM_ACCESS: begin
          mem_dir_hi_q <= cmd_val[2];
          mem_dir_lo_q <= cmd_val[1];
          incr_axis_sel_q <= cmd_val[0];
        end
        `OPRI_CMD_COL_START: col_start_q <= cmd_val;
        `OPRI_CMD_COL_END: col_end_q <= cmd_val;
        `OPRI_CMD_ROW_START: row_start_q <= cmd_val;
        `OPRI_CMD_ROW_END: row_end_q <= cmd_val;
        `OPRI_CMD_DISCHARGE: discharge_q <= cmd_val;
        `OPRI_CMD_PEAK_DELAY: peak_delay_q <= cmd_val;
        `OPRI_CMD_PEAK_W_R: peak_w_r_q <= cmd_val;
        `OPRI_CMD_PEAK_W_G: peak_w_g_q <= cmd_val;
        `OPRI_CMD_PEAK_W_B: peak_w_b_q <= cmd_val;
        `OPRI_CMD_PRE_R: pre_r_q <= cmd_val;
        `OPRI_CMD_PRE_G: pre_g_q <= cmd_val;
        `OPRI_CMD_PRE_B: pre_b_q <= cmd_val;
        `OPRI_CMD_DRV_R: drv_r_q <= cmd_val;
        `OPRI_CMD_DRV_G: drv_g_q <= cmd_val;
        `OPRI_CMD_DRV_B: drv_b_q <= cmd_val;
        default: disp_q <= disp_q;
      endcase
    end
  end

  // ================================================================
  // Pin outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      panel_hv_on <= 1'b0;
      display_on <= 1'b0;
      osc_run <= 1'b0;
    end else begin
      panel_hv_on <= hv_pin_s || ctrl_hv_q; // R22
      display_on <= disp_q && !standby_q;
      osc_run <= osc_q;
    end
  end

  // ================================================================
  // AXI4-Lite read path
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `OPRI_REG_CTRL: rd_mux = {30'h0, ctrl_hv_q, ctrl_init_q};
      `OPRI_REG_CMD: rd_mux = 32'h0000_0000;
      // Column count stops at 287, so ten bits carry it in full
      `OPRI_REG_STAT: rd_mux = {scan_col[9:0], scan_row, frame_q[6:0],
        incr_axis_sel_q, mem_dir_lo_q, mem_dir_hi_q,
        init_hold, standby_q, osc_q, disp_q};
      `OPRI_REG_WIN: rd_mux = {row_end_q, row_start_q, col_end_q,
        col_start_q};
      `OPRI_REG_VIEW: rd_mux = {view_row_last_q, view_row_first_q,
        view_col_last_q, view_col_first_q};
      `OPRI_REG_TIME: rd_mux = {peak_w_b_q, peak_w_g_q ^ peak_w_r_q ^
        peak_w_r_q, peak_delay_q, discharge_q};
      `OPRI_REG_CUR: rd_mux = {8'h00, pre_b_q ^ drv_b_q,
        pre_g_q ^ drv_g_q, pre_r_q ^ drv_r_q};
      `OPRI_REG_RDPTR: rd_mux = {16'h0000, read_row_ptr_q,
        read_col_ptr_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (s_axi_araddr[7:5] != 3'b000) ? 2'b10 : 2'b00;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hdl/opri_defines.vh]
// Constants for the OLED power, reset and init block
`ifndef OPRI_DEFINES_VH
`define OPRI_DEFINES_VH
// ==================================================================
// Register byte offsets
`define OPRI_REG_CTRL 8'h00
`define OPRI_REG_CMD 8'h04
`define OPRI_REG_STAT 8'h08
`define OPRI_REG_WIN 8'h0c
`define OPRI_REG_VIEW 8'h10
`define OPRI_REG_TIME 8'h14
`define OPRI_REG_CUR 8'h18
`define OPRI_REG_RDPTR 8'h1c
// ==================================================================
// Control bit positions
`define OPRI_CTRL_INIT_N 0
`define OPRI_CTRL_HV 1
// ==================================================================
// Reset values and last scan row/column
`define OPRI_RST_COL_START 8'h00
`define OPRI_RST_COL_END 8'h5f
`define OPRI_RST_ROW_START 8'h00
`define OPRI_RST_ROW_END 8'h5f
`define OPRI_RST_FRAME_HZ 8'h5f
`define OPRI_RST_DISCHARGE 8'h08
`define OPRI_RST_PEAK_DELAY 8'h05
`define OPRI_RST_PEAK_WIDTH 8'h05
`define OPRI_RST_CURRENT 8'h00
`define OPRI_LAST_ROW 8'h5f
`define OPRI_LAST_COL 12'h11f
// ==================================================================
// Command codes
`define OPRI_CMD_SOFT_RESET 8'h01
`define OPRI_CMD_DISP_ON_OFF 8'h02
`define OPRI_CMD_MEM_ACCESS 8'h1d
`define OPRI_CMD_STANDBY 8'h14
`define OPRI_CMD_OSC 8'h1a
`define OPRI_CMD_DISCHARGE 8'h18
`define OPRI_CMD_PEAK_DELAY 8'h16
`define OPRI_CMD_COL_START 8'h30
`define OPRI_CMD_COL_END 8'h31
`define OPRI_CMD_ROW_START 8'h32
`define OPRI_CMD_ROW_END 8'h33
`define OPRI_CMD_PEAK_W_R 8'h3a
`define OPRI_CMD_PEAK_W_G 8'h3b
`define OPRI_CMD_PEAK_W_B 8'h3c
`define OPRI_CMD_PRE_R 8'h3d
`define OPRI_CMD_PRE_G 8'h3e
`define OPRI_CMD_PRE_B 8'h3f
`define OPRI_CMD_DRV_R 8'h40
`define OPRI_CMD_DRV_G 8'h41
`define OPRI_CMD_DRV_B 8'h42
`endif

// [hdl/opri_sync.v]
// Two-stage synchroniser for a pin level
`timescale 1ns/1ns
`default_nettype none
module opri_sync (
  input wire aclk,
  input wire aresetn,
  input wire rst_val,
  input wire d,
  output reg q
);
  reg meta_q;
  // Reset takes a constant per stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= rst_val;
      q <= rst_val;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [hdl/opri_scan.v]
// Row and column scan counters
`timescale 1ns/1ns
`default_nettype none
`include "opri_defines.vh"
module opri_scan (
  input wire aclk,
  input wire hold,
  input wire run,
  output reg [7:0] row_q,
  output reg [11:0] col_q
);
  // Ascending scan, restarting at zero
  always @(posedge aclk) begin
    if (hold || !run) begin
      row_q <= 8'h00;
      col_q <= 12'h000;
    end else if (col_q == `OPRI_LAST_COL) begin
      col_q <= 12'h000; // R09
      row_q <= (row_q == `OPRI_LAST_ROW) ? 8'h00 : row_q + 8'h01; // R08
    end else begin
      col_q <= col_q + 12'h001; // R09
    end
  end
endmodule
`default_nettype wire

// [dv/opri_chk_assertions.sv]
// Port checker for the power and init block
`timescale 1ns/1ns
`default_nettype none
module opri_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic chip_init_n,
  input wire logic panel_hv_enable,
  input wire logic panel_hv_on,
  input wire logic display_on,
  input wire logic osc_run
);
  // ==========================================
  // Helpers
  logic [3:0] lo_q;
  logic [7:0] ra_q;
  logic rl_q;
  // Long low count covers the pin synchroniser lag
  always_ff @(posedge aclk) begin
    if (!aresetn || chip_init_n) begin
      lo_q <= 4'h0;
    end else if (lo_q != 4'hf) begin
      lo_q <= lo_q + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rl_q <= 1'b0;
      ra_q <= 8'h00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rl_q <= lo_q > 4'h6;
      ra_q <= s_axi_araddr;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_hv_follow: assert property (panel_hv_enable [*4] |=> panel_hv_on)
    else $error("panel supply missed enable");
  a_init_disp: assert property (!chip_init_n [*6] |=> !display_on)
    else $error("display on under init");
  a_init_osc: assert property (!chip_init_n [*6] |=> !osc_run)
    else $error("oscillator on under init");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ptr_def: assert property (s_axi_rvalid && rl_q && ra_q == 8'h1c
    |-> s_axi_rdata == 32'h0)
    else $error("read pointers not default");
  a_time_def: assert property (s_axi_rvalid && rl_q && ra_q == 8'h14
    |-> s_axi_rdata == 32'h05050508)
    else $error("pulse timing not default");
  c_hv: cover property ($rose(panel_hv_on));
  c_disp: cover property ($rose(display_on));
  c_init: cover property (!chip_init_n ##1 chip_init_n);
endmodule
bind opri_top opri_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .chip_init_n(chip_init_n), .panel_hv_enable(panel_hv_enable),
  .panel_hv_on(panel_hv_on), .display_on(display_on), .osc_run(osc_run));
`default_nettype wire

// [dv/opri_host.sv]
// Host model driving the init pin and panel supply
`timescale 1ns/1ns
`default_nettype none
module opri_host #(
  parameter int WAIT_CYC = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [1:0] op,
  output logic chip_init_n,
  output logic panel_hv_enable,
  output logic busy
);
  int cnt;
  // Scaled settle wait; 100 ms would dwarf the run
  always @(posedge aclk) begin
    if (!aresetn) begin
      chip_init_n <= 1'b0;
      panel_hv_enable <= 1'b0;
      busy <= 1'b0;
      cnt <= 0;
    end else if (busy) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        busy <= 1'b0;
        chip_init_n <= 1'b1;
      end
    end else if (go) begin
      busy <= 1'b1;
      cnt <= WAIT_CYC;
      chip_init_n <= op != 2'd0;
      panel_hv_enable <= op == 2'd1;
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the power and init block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, go = 1'b0;
  logic [1:0] op = 2'd0;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic hv_on, disp_on, osc_on, init_n, hv_en;
  int err_total = 0, checked = 0, cyc = 0, seed = 21550;
  int m_t[4];
  int m_disp, m_stby, m_osc, m_hv;
  always #5 aclk = ~aclk;
  opri_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_init_n(init_n),
    .panel_hv_enable(hv_en), .panel_hv_on(hv_on), .display_on(disp_on),
    .osc_run(osc_on));
  opri_host #(.WAIT_CYC(64)) u_host (.aclk(aclk), .aresetn(aresetn),
    .go(go), .op(op), .chip_init_n(init_n), .panel_hv_enable(hv_en),
    .busy(busy));
  // ==========================================
  // Tasks
  task automatic cmp(input string n, input logic [31:0] e,
      input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // Leading edge keeps ready from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic defs();
    m_t = '{8, 5, 5, 5};
    m_disp = 0;
    m_stby = 1;
    m_osc = 0;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] v);
    wr(8'h04, {16'h0, c, v});
    case (c)
      8'h18: m_t[0] = v;
      8'h16: m_t[1] = v;
      8'h3b: m_t[2] = v;
      8'h3c: m_t[3] = v;
      8'h02: m_disp = v[0];
      8'h14: m_stby = v[0];
      8'h1a: m_osc = v[0];
      8'h01: defs();
      default: ;
    endcase
  endtask
  task automatic chk_time();
    rd(8'h14);
    cmp("time", {m_t[3][7:0], m_t[2][7:0], m_t[1][7:0], m_t[0][7:0]}, d);
  endtask
  task automatic rnd_time();
    logic [7:0] c[4] = '{8'h18, 8'h16, 8'h3b, 8'h3c};
    for (int i = 0; i < 4; i++) begin
      cmd(c[i], 8'($random(seed)) & 8'h0f);
    end
    chk_time();
  endtask
  task automatic chk_io();
    repeat (4) @(posedge aclk);
    cmp("display_on", m_disp == 1 && m_stby == 0, disp_on);
    cmp("osc_run", m_osc == 1, osc_on);
    cmp("panel_hv_on", m_hv == 1, hv_on);
  endtask
  task automatic hop(input logic [1:0] o);
    op <= o;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    m_hv = o == 2'd1;
    if (o == 2'd0) defs();
  endtask
  task automatic hwait();
    do @(posedge aclk); while (busy);
  endtask
  task automatic wrap_up();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  // ==========================================
  // Sequence
  initial begin
    defs();
    m_hv = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    hop(2'd0);
    repeat (10) @(posedge aclk);
    chk_time();
    rd(8'h1c);
    cmp("rdptr", 32'h0, d);
    hwait();
    $display("test init_hold done");
    chk_io();
    rd(8'h00);
    cmp("ctrl", 32'h1, d);
    rd(8'h0c);
    cmp("win", 32'h5f005f00, d);
    rd(8'h10);
    cmp("view", 32'h5f005f00, d);
    rd(8'h18);
    cmp("cur", 32'h0, d);
    rd(8'h20);
    cmp("bad rd", 32'h2, d | r);
    wr(8'h24, 32'h0);
    cmp("bad wr", 32'h2, r);
    $display("test defaults done");
    cmd(8'h01, 8'h00);
    cmd(8'h14, 8'h00);
    cmd(8'h1d, 8'h01);
    for (int i = 0; i < 4; i++) begin
      cmd(8'h30 + 8'(i), i[0] ? 8'h5f : 8'h00);
    end
    rnd_time();
    cmd(8'h1a, 8'h01);
    cmd(8'h02, 8'h01);
    hop(2'd1);
    hwait();
    chk_io();
    $display("test setup done");
    cmd(8'h01, 8'h00);
    chk_io();
    chk_time();
    rnd_time();
    cmd(8'h02, 8'h00);
    hop(2'd2);
    hwait();
    hop(2'd0);
    hwait();
    chk_io();
    chk_time();
    $display("test power_down done");
    wrap_up();
  end
endmodule
`default_nettype wire
